// *** logic/txdc_pkg.sv ***
// Constants and types for the transmit descriptor chaining engine
package txdc_pkg;
  localparam int WB_AW = 8;
  localparam int MEM_AW = 24;
  localparam int DESC_W = 16;
  localparam int IDX_W_DEF = 8;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_BASE = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0c;
  localparam logic [7:0] REG_IDX = 8'h10;
  // Control bits: start, stop and poll act on write of one
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_POLL = 3;
  localparam int CTRL_KEEP = 6;
  // Status bits; error bits are sticky, write one to clear
  localparam int STAT_TRANSMITTER_ON_BIT = 0;
  localparam int STAT_BUFFER_ERROR_FLAG = 1;
  localparam int STAT_UNDERFLOW_ERROR_FLAG = 2;
  localparam int STAT_BUSY = 3;
  // Descriptor word 1 layout
  localparam int W1_OWN = 15;
  localparam int W1_ERR = 14;
  localparam int W1_FIRST = 9;
  localparam int W1_LAST = 8;
  // Descriptor word 2 (error word) layout
  localparam int W2_BUFFER_ERROR_FLAG = 15;
  localparam int W2_UNDERFLOW_ERROR_FLAG = 14;
  localparam int W2_LATE_COLLISION_FLAG = 12;
  localparam int W2_CARRIER_LOSS_FLAG = 11;
  localparam int W2_RETRY_FAILURE_FLAG = 10;
  // Descriptor geometry in bytes
  localparam int DESC_SHIFT = 3;
  localparam logic [23:0] W1_OFF = 24'h000002;
  localparam logic [23:0] W2_OFF = 24'h000004;
  localparam logic [23:0] BASE_RST = 24'h000000;
  localparam logic keep_rst = 1'b0;
  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_EVAL, S_SEND, S_LOOK, S_WB1, S_WB2
  } txdc_state_type;
endpackage

// *** logic/txdc_engine.sv ***
// Transmit descriptor chaining engine with Wishbone register slave
//
// Summary of operation
// - Skip owned descriptors lacking first flag
// - Bit 8 marks last; first+last means unchained
// - First and last flags never modified here
// - Address high byte never modified here
// - Next buffer not owned sets buffer error
// - Underflow before next status fetch: buffer error
// - Buffer error stops transmitter unless keep bit
// - Buffer error always sets underflow error too
// - Buffer error void with late collision/retry
// - FIFO empty early sets underflow, truncates
// - Underflow stops transmitter unless keep bit
// - Bit 15 set means controller holds descriptor
// - Clear holder flag after buffer transmitted
// - Summary error is OR of four flags
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module txdc_engine
  import txdc_pkg::*;
#(
  parameter int IDX_W = IDX_W_DEF
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [txdc_pkg::WB_AW-1:0] adr_i, // Wishbone address
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  input wire logic we_i, // Wishbone write
  input wire logic [3:0] sel_i, // Wishbone byte lanes
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  output logic ack_o, // Wishbone ack
  output logic mem_req_o, // Descriptor memory request
  output logic mem_we_o, // Descriptor memory write
  output logic [txdc_pkg::MEM_AW-1:0] mem_addr_o, // Byte address
  output logic [txdc_pkg::DESC_W-1:0] mem_wdata_o, // Write data
  input wire logic mem_ack_i, // Memory done
  input wire logic [txdc_pkg::DESC_W-1:0] mem_rdata_i, // Read data
  output logic buf_start_o, // Pulse: start next buffer
  output logic [7:0] buffer_addr_high_o, // Buffer address high
  output logic buf_last_o, // Started buffer ends frame
  input wire logic buf_done_i, // Buffer moved to FIFO
  input wire logic fifo_underflow_i, // FIFO ran dry mid frame
  input wire logic late_collision_i, // Late collision pulse
  input wire logic retry_failure_i, // Retry failure pulse
  input wire logic carrier_loss_i, // Carrier loss pulse
  output logic frame_abort_o, // Pulse: truncate frame
  output logic transmitter_on_o // Transmitter enabled
);
  import txdc_pkg::*;
  initial begin
    if (IDX_W < 1 || IDX_W > 16) begin
      $error("IDX_W must be 1 to 16");
    end
  end
  function automatic logic [MEM_AW-1:0] desc_addr(
    input logic [MEM_AW-1:0] base,
    input logic [IDX_W-1:0] idx,
    input logic [MEM_AW-1:0] off);
    logic [MEM_AW-1:0] ofs;
    ofs = MEM_AW'({idx, DESC_SHIFT'(0)});
    return base + ofs + off;
  endfunction

  txdc_state_type state;
  logic [DESC_W-1:0] cur_w1, nxt_w1, next_w2;
  logic [IDX_W-1:0] idx, last_idx, next_idx;
  logic [MEM_AW-1:0] base;
  logic keep_tx_on_underflow, transmitter_on_bit, poll_pend, chain_go;
  logic st_buffer_error_flag, st_ufl, buffer_error_flag_r, ufl_r, late_collision_flag_r, carrier_loss_flag_r, retry_failure_flag_r, buffer_error_flag_valid;
  logic wb_hit, wr_ctrl, wr_stat, buffer_error_flag_ev, ufl_ev, err_ev;

  assign transmitter_on_o = transmitter_on_bit;
  assign next_idx = (idx == last_idx) ? '0 : idx + 1'b1;

  // Wishbone slave: one wait state, ack drops after one cycle
  assign wb_hit = cyc_i && stb_i && !ack_o;
  assign wr_ctrl = wb_hit && we_i && sel_i[0] && adr_i == REG_CTRL;
  assign wr_stat = wb_hit && we_i && sel_i[0] && adr_i == REG_STAT;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (wb_hit && !we_i) begin
      case (adr_i)
        REG_CTRL: dat_o <= 32'(keep_tx_on_underflow) << CTRL_KEEP;
        REG_STAT: dat_o <= 32'({state != S_IDLE, st_ufl, st_buffer_error_flag,
                                transmitter_on_bit});
        REG_BASE: dat_o <= 32'(base);
        REG_LAST: dat_o <= 32'(last_idx);
        REG_IDX: dat_o <= 32'(idx);
        default: dat_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keep_tx_on_underflow <= keep_rst;
      base <= BASE_RST;
      last_idx <= '1;
    end else if (wb_hit && we_i) begin
      if (adr_i == REG_CTRL && sel_i[0]) begin
        keep_tx_on_underflow <= dat_i[CTRL_KEEP];
      end
      if (adr_i == REG_BASE) begin
        if (sel_i[0]) base[7:0] <= dat_i[7:0];
        if (sel_i[1]) base[15:8] <= dat_i[15:8];
        if (sel_i[2]) base[23:16] <= dat_i[23:16];
      end
      if (adr_i == REG_LAST && sel_i[0]) begin
        last_idx <= dat_i[IDX_W-1:0];
      end
    end
  end

  // Error events; a buffer error always drags an underflow along
  // Underflow counts from the first look-ahead cycle, before the request is up
  assign buffer_error_flag_ev = state == S_LOOK && !buffer_error_flag_r &&
                   (fifo_underflow_i ||
                    (mem_req_o && mem_ack_i && !mem_rdata_i[W1_OWN]));
  assign ufl_ev = buffer_error_flag_ev ||
                  (state == S_SEND && fifo_underflow_i);
  assign err_ev = ufl_ev;

  // Hardware stop beats a software start in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmitter_on_bit <= 1'b0;
    end else if (err_ev && !keep_tx_on_underflow) begin
      transmitter_on_bit <= 1'b0;
    end else if (wr_ctrl && dat_i[CTRL_STOP]) begin
      transmitter_on_bit <= 1'b0;
    end else if (wr_ctrl && dat_i[CTRL_START]) begin
      transmitter_on_bit <= 1'b1;
    end
  end

  // Sticky status: a new error wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_buffer_error_flag <= 1'b0;
      st_ufl <= 1'b0;
    end else begin
      if (buffer_error_flag_ev) begin
        st_buffer_error_flag <= 1'b1;
      end else if (wr_stat && dat_i[STAT_BUFFER_ERROR_FLAG]) begin
        st_buffer_error_flag <= 1'b0;
      end
      if (ufl_ev) begin
        st_ufl <= 1'b1;
      end else if (wr_stat && dat_i[STAT_UNDERFLOW_ERROR_FLAG]) begin
        st_ufl <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      poll_pend <= 1'b0;
    end else if (wr_ctrl && (dat_i[CTRL_POLL] || dat_i[CTRL_START])) begin
      poll_pend <= 1'b1;
    end else if (state == S_IDLE && transmitter_on_bit) begin
      poll_pend <= 1'b0;
    end
  end

  // Per-frame error flags, cleared when a frame begins
  always_ff @(posedge clk_i) begin
    if (rst_i || (state == S_EVAL && cur_w1[W1_FIRST])) begin
      buffer_error_flag_r <= 1'b0;
      ufl_r <= 1'b0;
      late_collision_flag_r <= 1'b0;
      carrier_loss_flag_r <= 1'b0;
      retry_failure_flag_r <= 1'b0;
    end else begin
      if (buffer_error_flag_ev) buffer_error_flag_r <= 1'b1;
      if (ufl_ev) ufl_r <= 1'b1;
      if (late_collision_i) late_collision_flag_r <= 1'b1;
      if (carrier_loss_i) carrier_loss_flag_r <= 1'b1;
      if (retry_failure_i) retry_failure_flag_r <= 1'b1;
    end
  end

  // Buffer error is meaningless after late collision or retry failure
  assign buffer_error_flag_valid = buffer_error_flag_r && !late_collision_flag_r && !retry_failure_flag_r;
  assign next_w2 = DESC_W'({buffer_error_flag_valid, ufl_r, 1'b0, late_collision_flag_r, carrier_loss_flag_r,
                            retry_failure_flag_r}) << W2_RETRY_FAILURE_FLAG;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      idx <= '0;
      cur_w1 <= '0;
      nxt_w1 <= '0;
      chain_go <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
      buf_start_o <= 1'b0;
      buf_last_o <= 1'b0;
      buffer_addr_high_o <= 8'h00;
      frame_abort_o <= 1'b0;
    end else begin
      buf_start_o <= 1'b0;
      frame_abort_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (transmitter_on_bit && poll_pend) begin
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (!mem_req_o) begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= desc_addr(base, idx, W1_OFF);
          end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            cur_w1 <= mem_rdata_i;
            state <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (!transmitter_on_bit || !cur_w1[W1_OWN]) begin
            state <= S_IDLE;
          end else if (!cur_w1[W1_FIRST]) begin
            idx <= next_idx;
            state <= S_FETCH;
          end else begin
            buf_start_o <= 1'b1;
            buffer_addr_high_o <= cur_w1[7:0];
            buf_last_o <= cur_w1[W1_LAST];
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (fifo_underflow_i) begin
            frame_abort_o <= 1'b1;
            chain_go <= 1'b0;
            state <= S_WB1;
          end else if (buf_done_i) begin
            chain_go <= 1'b0;
            state <= cur_w1[W1_LAST] ? S_WB1 : S_LOOK;
          end
        end
        S_LOOK: begin
          // Look ahead at the next status word while the FIFO drains
          if (!mem_req_o) begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= desc_addr(base, next_idx, W1_OFF);
          end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            nxt_w1 <= mem_rdata_i;
            chain_go <= !buffer_error_flag_ev && !buffer_error_flag_r;
            if (buffer_error_flag_ev || buffer_error_flag_r) begin
              frame_abort_o <= 1'b1;
            end
            state <= S_WB1;
          end
        end
        S_WB1: begin
          if (!mem_req_o) begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= desc_addr(base, idx, W1_OFF);
            // Hand back: holder cleared, flags and address kept
            mem_wdata_o <= {1'b0, |{ufl_r, late_collision_flag_r, carrier_loss_flag_r, retry_failure_flag_r},
                            cur_w1[13:0]};
          end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            state <= S_WB2;
          end
        end
        S_WB2: begin
          if (!mem_req_o) begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= desc_addr(base, idx, W2_OFF);
            mem_wdata_o <= next_w2;
          end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            idx <= next_idx;
            if (chain_go) begin
              cur_w1 <= nxt_w1;
              buf_start_o <= 1'b1;
              buffer_addr_high_o <= nxt_w1[7:0];
              buf_last_o <= nxt_w1[W1_LAST];
              state <= S_SEND;
            end else begin
              // After an error the rest of the frame is skipped
              state <= transmitter_on_bit ? S_FETCH : S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Checks on the engine's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  flags_kept_a: assert property (
    state == S_WB1 && mem_req_o && mem_we_o |-> mem_wdata_o[9:0] == cur_w1[9:0])
    else $error("first, last or address byte altered");
  owner_returned_a: assert property (
    state == S_WB1 && mem_req_o && mem_we_o |-> !mem_wdata_o[W1_OWN])
    else $error("descriptor returned still held");
  // Only the first request cycle still has word 1 in the previous sample
  summary_error_a: assert property (
    state == S_WB2 && $rose(mem_req_o) |-> $past(mem_wdata_o[W1_ERR]) ==
      |{mem_wdata_o[W2_UNDERFLOW_ERROR_FLAG], mem_wdata_o[W2_LATE_COLLISION_FLAG],
        mem_wdata_o[W2_CARRIER_LOSS_FLAG], mem_wdata_o[W2_RETRY_FAILURE_FLAG]})
    else $error("summary error not OR of flags");
  buffer_error_flag_implies_underflow_error_flag_a: assert property (
    state == S_WB2 && mem_req_o && mem_wdata_o[W2_BUFFER_ERROR_FLAG] |-> mem_wdata_o[W2_UNDERFLOW_ERROR_FLAG])
    else $error("buffer error without underflow");
  buffer_error_flag_void_a: assert property (
    state == S_WB2 && mem_req_o && (mem_wdata_o[W2_LATE_COLLISION_FLAG] || mem_wdata_o[W2_RETRY_FAILURE_FLAG]) |->
      !mem_wdata_o[W2_BUFFER_ERROR_FLAG])
    else $error("buffer error reported after collision");
  not_owned_a: assert property (
    state == S_LOOK && mem_req_o && mem_ack_i &&
      !mem_rdata_i[W1_OWN] |=> buffer_error_flag_r && ufl_r && frame_abort_o)
    else $error("unowned next buffer not flagged");
  early_empty_a: assert property (
    state == S_LOOK && !mem_ack_i && fifo_underflow_i |=> buffer_error_flag_r && ufl_r)
    else $error("underflow before status fetch missed");
  truncate_a: assert property (
    state == S_SEND && fifo_underflow_i |=> frame_abort_o && ufl_r && state == S_WB1)
    else $error("underflow did not truncate frame");
  tx_stop_a: assert property (
    err_ev && !keep_tx_on_underflow |=> !transmitter_on_bit [*2])
    else $error("transmitter stayed on after error");
  tx_keep_a: assert property (
    err_ev && keep_tx_on_underflow && transmitter_on_bit && !wr_ctrl |=> transmitter_on_bit)
    else $error("transmitter stopped despite keep bit");
  skip_start_a: assert property (
    state == S_EVAL && transmitter_on_bit && cur_w1[W1_OWN] &&
      !cur_w1[W1_FIRST] |=> state == S_FETCH && !buf_start_o)
    else $error("descriptor without first flag not skipped");
  start_owned_a: assert property (
    buf_start_o |-> cur_w1[W1_OWN] && buf_last_o == cur_w1[W1_LAST])
    else $error("buffer started without ownership");
  single_buf_c: cover property (
    state == S_EVAL && cur_w1[W1_FIRST] && cur_w1[W1_LAST]);
  chained_c: cover property (
    state == S_WB2 && mem_ack_i && chain_go);
  buffer_error_flag_err_c: cover property (buffer_error_flag_ev);
  keep_on_c: cover property (err_ev && keep_tx_on_underflow);
endmodule

// *** testbench/txdc_host_mem.sv ***
// Host-side descriptor memory answering the engine's memory port
`timescale 1ns/1ps
module txdc_host_mem (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic mem_req_i, // Access request
  input wire logic mem_we_i, // Write access
  input wire logic [23:0] mem_addr_i, // Byte address
  input wire logic [15:0] mem_wdata_i, // Write data
  output logic mem_ack_o, // Done pulse
  output logic [15:0] mem_rdata_o // Read data
);
  logic [15:0] mem [0:255];
  int lat = 1;
  int cnt = 0;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
    mem_ack_o = 1'b0;
    mem_rdata_o = 16'h0000;
  end
  // Read data toggles outside ack so a stale word is never mistaken for a fresh one
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (rst_i) begin
      cnt <= 0;
    end else if (mem_req_i && !mem_ack_o) begin
      if (cnt >= lat) begin
        cnt <= 0;
        mem_ack_o <= 1'b1;
        if (mem_we_i) begin
          mem[mem_addr_i[8:1]] <= mem_wdata_i; // Host leaves handed-over words alone
        end else begin
          mem_rdata_o <= mem[mem_addr_i[8:1]]; // Holder flag read at bit 15
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the transmit descriptor chaining engine
`timescale 1ns/1ps
module testbench;
  import txdc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
  logic [3:0] sel_i = 4'h0;
  logic mem_req_o, mem_we_o, mem_ack_i, buf_start_o, buf_last_o, frame_abort_o;
  logic transmitter_on_o;
  logic [23:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  logic [7:0] buffer_addr_high_o;
  logic buf_done_i = 1'b0, fifo_underflow_i = 1'b0, late_collision_i = 1'b0;
  logic retry_failure_i = 1'b0, carrier_loss_i = 1'b0;
  logic inj_mid = 1'b0, inj_after = 1'b0, inj_col = 1'b0, aborted = 1'b0;
  logic [8:0] started [$];
  int err_count = 0, n_compared = 0, k;
  // Descriptors: word1 as loaded, word1 and word2 after the run, buffer started
  logic [15:0] row_in [6] = '{16'h8305, 16'h81aa, 16'h83ff, 16'h8211, 16'h8122, 16'h0300};
  logic [15:0] row_w1 [6] = '{16'h0305, 16'h81aa, 16'h03ff, 16'h0211, 16'h0122, 16'h0300};
  logic [15:0] row_w2 [6] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'hffff};
  logic row_go [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  txdc_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .buf_start_o(buf_start_o), .buffer_addr_high_o(buffer_addr_high_o),
    .buf_last_o(buf_last_o), .buf_done_i(buf_done_i), .fifo_underflow_i(fifo_underflow_i),
    .late_collision_i(late_collision_i), .retry_failure_i(retry_failure_i),
    .carrier_loss_i(carrier_loss_i), .frame_abort_o(frame_abort_o),
    .transmitter_on_o(transmitter_on_o));
  txdc_host_mem i_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (frame_abort_o === 1'b1) begin
      aborted <= 1'b1;
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // Start or poll, then wait until the engine reports idle
  task automatic kick(input logic [31:0] ctrl);
    int n;
    aborted <= 1'b0;
    started.delete();
    wb(1'b1, REG_CTRL, ctrl);
    n = 0;
    do begin
      wb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 200);
    chk("idle", 32'(rd[STAT_BUSY]), 32'h0);
  endtask
  // Host fills both words before setting the holder flag
  task automatic load(input int i, input logic [15:0] w1);
    i_mem.mem[i*4+2] = 16'hffff;
    i_mem.mem[i*4+1] = w1;
  endtask
  task automatic desc(input int i, input logic [15:0] w1, input logic [15:0] w2);
    chk($sformatf("word1 of %0d", i), 32'(i_mem.mem[i*4+1]), 32'(w1));
    chk($sformatf("word2 of %0d", i), 32'(i_mem.mem[i*4+2]), 32'(w2));
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Datapath stand-in: takes each started buffer, optionally failing mid-way
  initial forever begin
    @(posedge clk_i);
    if (buf_start_o === 1'b1) begin
      started.push_back({buf_last_o, buffer_addr_high_o});
      repeat (2) @(posedge clk_i);
      fifo_underflow_i <= inj_mid;
      late_collision_i <= inj_col;
      retry_failure_i <= inj_col;
      carrier_loss_i <= inj_col;
      @(posedge clk_i);
      fifo_underflow_i <= 1'b0;
      late_collision_i <= 1'b0;
      retry_failure_i <= 1'b0;
      carrier_loss_i <= 1'b0;
      buf_done_i <= !inj_mid;
      @(posedge clk_i);
      buf_done_i <= 1'b0;
      fifo_underflow_i <= inj_after;
      @(posedge clk_i);
      fifo_underflow_i <= 1'b0;
    end
  end

  initial begin
    #500000;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    wb(1'b0, REG_STAT, 32'h0);
    chk("stat", rd, 32'h0);
    wb(1'b0, REG_LAST, 32'h0);
    chk("last", rd, 32'h000000ff);
    wb(1'b1, 8'h14, 32'hffffffff);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, REG_LAST, 32'h0000000f);
    wb(1'b0, REG_LAST, 32'h0);
    chk("last", rd, 32'h0000000f);
    for (int i = 0; i < 6; i++) begin
      load(i, row_in[i]);
    end
    kick(32'h1);
    k = 0;
    for (int i = 0; i < 6; i++) begin
      desc(i, row_w1[i], row_w2[i]);
      if (row_go[i]) begin
        chk("start", 32'(started[k]), 32'({row_in[i][8], row_in[i][7:0]}));
        k++;
      end
    end
    chk("starts", 32'(started.size()), 32'(k));
    wb(1'b0, REG_IDX, 32'h0);
    chk("idx", rd, 32'h5);
    // Next buffer not held by the engine, transmitter must stop
    load(5, 16'h8233);
    load(6, 16'h0144);
    kick(32'h1);
    desc(5, 16'h4233, 16'hc000);
    desc(6, 16'h0144, 16'hffff);
    chk("abort", 32'(aborted), 32'h1);
    chk("tx on", 32'(transmitter_on_o), 32'h0);
    wb(1'b0, REG_STAT, 32'h0);
    chk("stat", rd, 32'h6);
    wb(1'b1, REG_STAT, 32'h6);
    wb(1'b0, REG_STAT, 32'h0);
    chk("stat", rd, 32'h0);
    // Same fault with late collision, retry failure and carrier loss, keep bit set
    load(6, 16'h8266);
    load(7, 16'h0177);
    inj_col = 1'b1;
    kick(32'h41);
    inj_col = 1'b0;
    desc(6, 16'h4266, 16'h5c00);
    chk("tx on", 32'(transmitter_on_o), 32'h1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h40);
    // Underflow before the next status word arrives from slow memory
    i_mem.lat = 8;
    inj_after = 1'b1;
    load(7, 16'h8288);
    load(8, 16'h8199);
    // Transmitter is still on, so a poll demand restarts the ring walk
    kick(32'h48);
    inj_after = 1'b0;
    i_mem.lat = 1;
    desc(7, 16'h4288, 16'hc000);
    desc(8, 16'h8199, 16'hffff);
    chk("starts", 32'(started.size()), 32'h1);
    chk("tx on", 32'(transmitter_on_o), 32'h1);
    // Underflow while a single-buffer frame is sent, keep bit clear
    inj_mid = 1'b1;
    load(9, 16'h83aa);
    kick(32'h1);
    inj_mid = 1'b0;
    desc(9, 16'h43aa, 16'h4000);
    chk("abort", 32'(aborted), 32'h1);
    chk("tx on", 32'(transmitter_on_o), 32'h0);
    end_sim();
  end
endmodule
